// >>> design/acdp_pkg.sv
// acdp_pkg: constants for the auxiliary control and dual pointer block
// assumes a 125 MHz system clock and an avalon-mm slave with 32-bit data
package acdp_pkg;
  localparam int          ACDP_AW           = 8;
  localparam int          ACDP_DW           = 32;
  localparam int          ACDP_PW           = 16;
  // register byte addresses
  localparam logic [7:0]  ACDP_OFS_AUX      = 8'ha2;
  localparam logic [7:0]  ACDP_OFS_PTR_LO   = 8'ha4;
  localparam logic [7:0]  ACDP_OFS_PTR_HI   = 8'ha8;
  localparam logic [7:0]  ACDP_OFS_STATUS   = 8'hac;
  // auxiliary control field positions
  localparam int          ACDP_B_SEL        = 0;
  localparam int          ACDP_B_SPARE      = 1;
  localparam int          ACDP_B_ZERO       = 2;
  localparam int          ACDP_B_SOFTWARE_RESET_TRIGGER       = 3;
  localparam int          ACDP_B_T0EN       = 4;
  localparam int          ACDP_B_T1EN       = 5;
  localparam int          ACDP_B_BRK        = 6;
  localparam int          ACDP_B_CLOCK_LOW_POWER_SELECT      = 7;
  localparam logic [7:0]  ACDP_AUX_RST      = 8'h00;
  localparam logic [7:0]  ACDP_AUX_WMASK    = 8'hfb;
  localparam logic [15:0] ACDP_PTR_RST      = 16'h0000;
  localparam logic [15:0] ACDP_PTR_ONE      = 16'h0001;
  // chip reset pulse length
  localparam int          ACDP_RST_NS       = 16;
  localparam int          ACDP_CLK_NS       = 8;
  localparam int          ACDP_RST_CYC      = (ACDP_RST_NS + ACDP_CLK_NS - 1) / ACDP_CLK_NS;
  localparam logic [31:0] ACDP_UNMAPPED     = 32'h0000_0000;
  // pointer operations issued by the core
  typedef enum logic [1:0] {
    ACDP_OP_NONE,
    ACDP_OP_INC,
    ACDP_OP_LOAD
  } acdp_op_t;
endpackage

// >>> design/acdp_sync.sv
// acdp_sync: two flip-flop synchroniser for pin inputs
// assumes a single clock domain on the sampling side
`timescale 1ns/1ps
module acdp_sync (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic d_i,
  output logic      q_o
);
  typedef struct packed {
    logic meta;
    logic q;
  } acdp_sync_t;
  acdp_sync_t s_r;
  acdp_sync_t s_nxt;
  always_comb begin
    s_nxt      = s_r;
    s_nxt.meta = d_i;
    s_nxt.q    = s_r.meta;
  end
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign q_o = s_r.q;
endmodule // acdp_sync

// >>> design/acdp_ptrs.sv
// acdp_ptrs: two 16-bit data pointers, one reachable through the select
// assumes operations come from the core on the same clock
`timescale 1ns/1ps
module acdp_ptrs #(
  parameter int PW = 16
) (
  input  wire logic          mclk_i,
  input  wire logic          rst_n_i,
  input  wire logic          sel_i,
  input  wire logic [1:0]    op_i,
  input  wire logic [PW-1:0] load_i,
  input  wire logic          wr_lo_i,
  input  wire logic          wr_hi_i,
  input  wire logic [7:0]    byte_i,
  output logic      [PW-1:0] cur_o
);
  import acdp_pkg::*;
  typedef struct packed {
    logic [1:0][PW-1:0] p;
  } acdp_ptrs_t;
  acdp_ptrs_t s_r;
  acdp_ptrs_t s_nxt;
  always_comb begin
    s_nxt = s_r;
    if (op_i == ACDP_OP_INC) begin
      s_nxt.p[sel_i] = s_r.p[sel_i] + PW'(ACDP_PTR_ONE);
    end else if (op_i == ACDP_OP_LOAD) begin
      s_nxt.p[sel_i] = load_i;
    end else begin
      if (wr_lo_i) begin
        s_nxt.p[sel_i][7:0] = byte_i;
      end
      if (wr_hi_i) begin
        s_nxt.p[sel_i][PW-1:8] = byte_i;
      end
    end
  end
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign cur_o = s_r.p[sel_i];
endmodule // acdp_ptrs

// >>> design/acdp_top.sv
// acdp_top: auxiliary control register, toggle pins, resets, dual pointers
// assumes an avalon-mm master, core strobes on mclk_i, overflow/break on pins
// Behaviour
// - bit 0 selects which of the two data pointers is active
// - bit 1 is spare; writing one has no effect on behaviour
// - bit 2 always reads zero so incrementing changes only bits 0 and 1
// - write with bit 3 set resets the chip like hardware reset, except that the programming flag is kept
// - bit 4 set inverts timer-0 toggle pin on each timer 0 overflow
// - bit 5 set inverts timer-1 toggle pin on each timer 1 overflow
// - bit 6 set makes a uart break reset chip into programming mode
// - bit 7 selects low-power clock, cleared on reset for 125 MHz
// - the unselected pointer is unreachable until the select changes
// - pointer increment adds one to the selected pointer only
// - immediate load writes a constant into the selected pointer only
// - byte register accesses and pointer addressing use the selected pointer
`timescale 1ns/1ps
module acdp_top (
  input  wire logic                           mclk_i,
  input  wire logic                           rst_n_i,
  input  wire logic [acdp_pkg::ACDP_AW-1:0]   avs_address_i,
  input  wire logic                           avs_read_i,
  input  wire logic                           avs_write_i,
  input  wire logic [acdp_pkg::ACDP_DW-1:0]   avs_writedata_i,
  input  wire logic [3:0]                     avs_byteenable_i,
  output logic      [acdp_pkg::ACDP_DW-1:0]   avs_readdata_o,
  output logic                                avs_waitrequest_o,
  input  wire logic [1:0]                     ptr_op_i,
  input  wire logic [acdp_pkg::ACDP_PW-1:0]   ptr_load_i,
  input  wire logic                           timer0_overflow_i,
  input  wire logic                           timer1_overflow_i,
  input  wire logic                           uart_break_i,
  output logic [acdp_pkg::ACDP_PW-1:0]        data_pointer_o,
  output logic                                timer0_toggle_pin_o,
  output logic                                timer1_toggle_pin_o,
  output logic                                chip_reset_o,
  output logic                                in_system_programming_mode_o,
  output logic                                clock_low_power_select_o
);
  import acdp_pkg::*;

  typedef struct packed {
    logic [7:0]         aux;
    logic               ack;
    logic               wreq;
    logic [ACDP_DW-1:0] rdata;
    logic [ACDP_PW-1:0] data_pointer;
    logic               t0pin;
    logic               t1pin;
    logic               t0_prev;
    logic               t1_prev;
    logic               brk_prev;
    logic [3:0]         rst_cnt;
    logic               chip_rst;
    logic               in_system_programming_mode;
  } acdp_top_t;

  localparam acdp_top_t ACDP_TOP_RST = '{wreq: 1'b1, default: '0};

  acdp_top_t          s_r;
  acdp_top_t          s_nxt;
  logic               t0_s;
  logic               t1_s;
  logic               brk_s;
  logic               req;
  logic               wr_hit;
  logic               wr_aux;
  logic               wr_lo;
  logic               wr_hi;
  logic [7:0]         wbyte;
  logic [ACDP_PW-1:0] cur_ptr;
  logic               int_rst_n;

  acdp_sync u_sync_t0 (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .d_i     (timer0_overflow_i),
    .q_o     (t0_s)
  );
  acdp_sync u_sync_t1 (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .d_i     (timer1_overflow_i),
    .q_o     (t1_s)
  );
  acdp_sync u_sync_brk (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .d_i     (uart_break_i),
    .q_o     (brk_s)
  );

  // the internal reset also clears the pointers as a hardware reset would; the programming flag survives it
  assign int_rst_n = rst_n_i & ~s_r.chip_rst;
  assign req       = (avs_read_i | avs_write_i) & ~s_r.ack & ~s_r.chip_rst;
  assign wr_hit    = avs_write_i & ~s_r.ack & ~s_r.chip_rst & avs_byteenable_i[0];
  assign wbyte     = avs_writedata_i[7:0];
  assign wr_aux    = wr_hit & (avs_address_i == ACDP_OFS_AUX);
  assign wr_lo     = wr_hit & (avs_address_i == ACDP_OFS_PTR_LO);
  assign wr_hi     = wr_hit & (avs_address_i == ACDP_OFS_PTR_HI);

  acdp_ptrs #(
    .PW (ACDP_PW)
  ) u_ptrs (
    .mclk_i  (mclk_i),
    .rst_n_i (int_rst_n),
    .sel_i   (s_r.aux[ACDP_B_SEL]),
    .op_i    (ptr_op_i),
    .load_i  (ptr_load_i),
    .wr_lo_i (wr_lo),
    .wr_hi_i (wr_hi),
    .byte_i  (wbyte),
    .cur_o   (cur_ptr)
  );

  always_comb begin
    s_nxt          = s_r;
    s_nxt.ack      = req;
    s_nxt.wreq     = ~req;
    s_nxt.t0_prev  = t0_s;
    s_nxt.t1_prev  = t1_s;
    s_nxt.brk_prev = brk_s;
    s_nxt.data_pointer     = cur_ptr;
    s_nxt.rdata    = ACDP_UNMAPPED;
    if (req & avs_read_i) begin
      unique case (avs_address_i)
        ACDP_OFS_AUX:    s_nxt.rdata = {24'h000000, s_r.aux};
        ACDP_OFS_PTR_LO: s_nxt.rdata = {24'h000000, cur_ptr[7:0]};
        ACDP_OFS_PTR_HI: s_nxt.rdata = {24'h000000, cur_ptr[15:8]};
        ACDP_OFS_STATUS: s_nxt.rdata = {30'h0, s_r.in_system_programming_mode, s_r.chip_rst};
        default:         s_nxt.rdata = ACDP_UNMAPPED;
      endcase
    end
    if (wr_aux) begin
      // bit 2 never stores; bit 1 stores but drives nothing
      s_nxt.aux = wbyte & ACDP_AUX_WMASK;
    end
    if (t0_s & ~s_r.t0_prev & s_r.aux[ACDP_B_T0EN]) begin
      s_nxt.t0pin = ~s_r.t0pin;
    end
    if (t1_s & ~s_r.t1_prev & s_r.aux[ACDP_B_T1EN]) begin
      s_nxt.t1pin = ~s_r.t1pin;
    end
    if (wr_aux & wbyte[ACDP_B_SOFTWARE_RESET_TRIGGER]) begin
      s_nxt.chip_rst = 1'b1;
      s_nxt.rst_cnt  = 4'(ACDP_RST_CYC);
    end
    if (s_r.chip_rst) begin
      // chip reset clears all but the programming flag, trigger bit included
      s_nxt          = ACDP_TOP_RST;
      s_nxt.aux      = ACDP_AUX_RST;
      s_nxt.data_pointer     = ACDP_PTR_RST;
      s_nxt.in_system_programming_mode      = s_r.in_system_programming_mode;
      s_nxt.t0_prev  = t0_s;
      s_nxt.t1_prev  = t1_s;
      s_nxt.brk_prev = brk_s;
      s_nxt.rst_cnt  = s_r.rst_cnt - 4'h1;
      s_nxt.chip_rst = (s_r.rst_cnt != 4'h1);
    end
    // a break edge wins over the end of a running chip reset
    if (brk_s & ~s_r.brk_prev & s_r.aux[ACDP_B_BRK]) begin
      s_nxt.chip_rst = 1'b1;
      s_nxt.in_system_programming_mode      = 1'b1;
      s_nxt.rst_cnt  = 4'(ACDP_RST_CYC);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s_r <= ACDP_TOP_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata_o               = s_r.rdata;
  assign avs_waitrequest_o            = s_r.wreq;
  assign data_pointer_o               = s_r.data_pointer;
  assign timer0_toggle_pin_o          = s_r.t0pin;
  assign timer1_toggle_pin_o          = s_r.t1pin;
  assign chip_reset_o                 = s_r.chip_rst;
  assign in_system_programming_mode_o = s_r.in_system_programming_mode;
  assign clock_low_power_select_o     = s_r.aux[ACDP_B_CLOCK_LOW_POWER_SELECT];

  property p_zero_bit;
    @(posedge mclk_i) disable iff (!rst_n_i) s_r.aux[ACDP_B_ZERO] == 1'b0;
  endproperty
  a_zero_bit: assert property (p_zero_bit) else $error("bit 2 not zero");

  property p_software_reset_trigger;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (wr_aux & wbyte[ACDP_B_SOFTWARE_RESET_TRIGGER]) |=> chip_reset_o;
  endproperty
  a_software_reset_trigger: assert property (p_software_reset_trigger) else $error("software reset missed");

  property p_software_reset_trigger_clear;
    @(posedge mclk_i) disable iff (!rst_n_i)
      $fell(chip_reset_o) |-> s_r.aux == ACDP_AUX_RST;
  endproperty
  a_software_reset_trigger_clear: assert property (p_software_reset_trigger_clear) else $error("aux not cleared");

  property p_t0;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (t0_s & ~s_r.t0_prev & s_r.aux[ACDP_B_T0EN] & ~s_r.chip_rst)
        |=> timer0_toggle_pin_o != $past(timer0_toggle_pin_o);
  endproperty
  a_t0: assert property (p_t0) else $error("timer0 pin not toggled");

  property p_t1_hold;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (~s_r.aux[ACDP_B_T1EN] & ~s_r.chip_rst) |=> $stable(timer1_toggle_pin_o);
  endproperty
  a_t1_hold: assert property (p_t1_hold) else $error("timer1 pin moved");

  property p_brk;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (brk_s & ~s_r.brk_prev & s_r.aux[ACDP_B_BRK]) |=> (chip_reset_o & in_system_programming_mode_o);
  endproperty
  a_brk: assert property (p_brk) else $error("break reset missed");

  property p_inc;
    @(posedge mclk_i) disable iff (!int_rst_n)
      (ptr_op_i == ACDP_OP_INC) ##1 $stable(s_r.aux[ACDP_B_SEL])
        |-> cur_ptr == $past(cur_ptr) + ACDP_PTR_ONE;
  endproperty
  a_inc: assert property (p_inc) else $error("increment wrong");

  property p_load;
    @(posedge mclk_i) disable iff (!int_rst_n)
      (ptr_op_i == ACDP_OP_LOAD) ##1 $stable(s_r.aux[ACDP_B_SEL]) |-> cur_ptr == $past(ptr_load_i);
  endproperty
  a_load: assert property (p_load) else $error("load wrong");

  property p_wait;
    @(posedge mclk_i) disable iff (!int_rst_n)
      (avs_read_i | avs_write_i) |-> ##[0:1] !avs_waitrequest_o;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer late");

  property p_wait_once;
    @(posedge mclk_i) disable iff (!rst_n_i)
      !avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_wait_once: assert property (p_wait_once) else $error("answer too long");

  property p_rd_idle;
    @(posedge mclk_i) disable iff (!rst_n_i)
      avs_waitrequest_o |-> avs_readdata_o == ACDP_UNMAPPED;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stale read data");

  property p_data_pointer;
    @(posedge mclk_i) disable iff (!int_rst_n)
      1'b1 |=> data_pointer_o == $past(cur_ptr);
  endproperty
  a_data_pointer: assert property (p_data_pointer) else $error("pointer output wrong");

  property p_sel_wr;
    @(posedge mclk_i) disable iff (!rst_n_i)
      wr_aux |=> s_r.aux[ACDP_B_SEL] == $past(wbyte[ACDP_B_SEL]);
  endproperty
  a_sel_wr: assert property (p_sel_wr) else $error("select not written");

  property p_spare;
    @(posedge mclk_i) disable iff (!rst_n_i)
      wr_aux |=> s_r.aux[ACDP_B_SPARE] == $past(wbyte[ACDP_B_SPARE]);
  endproperty
  a_spare: assert property (p_spare) else $error("spare bit not kept");

  property p_clock_low_power_select;
    @(posedge mclk_i)
      !rst_n_i |=> !clock_low_power_select_o;
  endproperty
  a_clock_low_power_select: assert property (p_clock_low_power_select) else $error("low power not cleared");

  property p_t0_hold;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (~s_r.aux[ACDP_B_T0EN] & ~s_r.chip_rst) |=> $stable(timer0_toggle_pin_o);
  endproperty
  a_t0_hold: assert property (p_t0_hold) else $error("timer0 pin moved");

  property p_t1;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (t1_s & ~s_r.t1_prev & s_r.aux[ACDP_B_T1EN] & ~s_r.chip_rst)
        |=> timer1_toggle_pin_o != $past(timer1_toggle_pin_o);
  endproperty
  a_t1: assert property (p_t1) else $error("timer1 pin not toggled");

  property p_brk_off;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (brk_s & ~s_r.brk_prev & ~s_r.aux[ACDP_B_BRK] & ~s_r.chip_rst & ~wr_aux)
        |=> !chip_reset_o;
  endproperty
  a_brk_off: assert property (p_brk_off) else $error("break reset while off");

  property p_isp_hold;
    @(posedge mclk_i) disable iff (!rst_n_i)
      in_system_programming_mode_o |=> in_system_programming_mode_o;
  endproperty
  a_isp_hold: assert property (p_isp_hold) else $error("programming mode lost");

  property p_rst_len;
    @(posedge mclk_i) disable iff (!rst_n_i)
      $rose(chip_reset_o) |-> ##1 chip_reset_o;
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("chip reset too short");

  property p_rst_end;
    @(posedge mclk_i) disable iff (!rst_n_i)
      chip_reset_o |-> ##[1:8] !chip_reset_o;
  endproperty
  a_rst_end: assert property (p_rst_end) else $error("chip reset stuck");

  property p_rst_out;
    @(posedge mclk_i) disable iff (!rst_n_i)
      chip_reset_o |=> !timer0_toggle_pin_o & !timer1_toggle_pin_o
        & (data_pointer_o == ACDP_PTR_RST);
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not reset");

  property p_software_reset_trigger_aux;
    @(posedge mclk_i) disable iff (!rst_n_i)
      chip_reset_o |=> s_r.aux == ACDP_AUX_RST;
  endproperty
  a_software_reset_trigger_aux: assert property (p_software_reset_trigger_aux) else $error("trigger not cleared");

  property p_unsel;
    @(posedge mclk_i) disable iff (!int_rst_n)
      ((ptr_op_i == ACDP_OP_NONE) & ~wr_lo & ~wr_hi) ##1 $stable(s_r.aux[ACDP_B_SEL])
        |-> $stable(cur_ptr);
  endproperty
  a_unsel: assert property (p_unsel) else $error("pointer changed unasked");

  property p_lo;
    @(posedge mclk_i) disable iff (!int_rst_n)
      (wr_lo & (ptr_op_i == ACDP_OP_NONE)) ##1 $stable(s_r.aux[ACDP_B_SEL])
        |-> cur_ptr[7:0] == $past(wbyte);
  endproperty
  a_lo: assert property (p_lo) else $error("low byte write wrong");

  property p_hi;
    @(posedge mclk_i) disable iff (!int_rst_n)
      (wr_hi & (ptr_op_i == ACDP_OP_NONE)) ##1 $stable(s_r.aux[ACDP_B_SEL])
        |-> cur_ptr[15:8] == $past(wbyte);
  endproperty
  a_hi: assert property (p_hi) else $error("high byte write wrong");

  c_software_reset_trigger: cover property (@(posedge mclk_i) $rose(chip_reset_o));
  c_isp:  cover property (@(posedge mclk_i) $rose(in_system_programming_mode_o));
  c_t0:   cover property (@(posedge mclk_i) $changed(timer0_toggle_pin_o));
  c_sel:  cover property (@(posedge mclk_i) $changed(s_r.aux[ACDP_B_SEL]));
endmodule // acdp_top

// >>> verif/acdp_core_model.sv
// acdp_core_model: processor core issuing pointer operations to the block
// assumes it shares mclk_i with the block and is driven by tasks from tb
`timescale 1ns/1ps
module acdp_core_model (
  input  wire logic                         mclk_i,
  output logic      [1:0]                   ptr_op_o,
  output logic      [acdp_pkg::ACDP_PW-1:0] ptr_load_o
);
  import acdp_pkg::*;
  initial begin
    ptr_op_o   = 2'h0;
    ptr_load_o = 16'h0000;
  end
  // one-cycle operation, then the value lines show the inverse
  task automatic op(input acdp_op_t code, input logic [15:0] val);
    @(posedge mclk_i);
    ptr_op_o   <= code;
    ptr_load_o <= val;
    @(posedge mclk_i);
    ptr_op_o   <= ACDP_OP_NONE;
    ptr_load_o <= ~val;
  endtask
endmodule // acdp_core_model

// >>> verif/tb.sv
// tb: self-checking bench for acdp_top
// assumes acdp_core_model as the core; pins driven here
`timescale 1ns/1ps
module tb;
  import acdp_pkg::*;
  logic        mclk_i  = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  adr     = 8'h00;
  logic        rd_r    = 1'b0;
  logic        wr_r    = 1'b0;
  logic [31:0] wd      = 32'h0;
  logic [3:0]  be      = 4'hf;
  logic [2:0]  pins    = 3'h0;
  logic [31:0] rdat;
  logic        wait_r;
  logic [1:0]  op;
  logic [15:0] ld;
  logic [15:0] ptr;
  logic        t0;
  logic        t1;
  logic        crst;
  logic        in_system_programming_mode;
  logic        clock_low_power_select;
  logic [31:0] q;
  int          err_total  = 0;
  int          n_compared = 0;
  int          rst_cyc    = 0;
  int          b;

  acdp_top acdp_top_inst (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(adr), .avs_read_i(rd_r),
    .avs_write_i(wr_r), .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wait_r), .ptr_op_i(op), .ptr_load_i(ld),
    .timer0_overflow_i(pins[0]), .timer1_overflow_i(pins[1]), .uart_break_i(pins[2]),
    .data_pointer_o(ptr), .timer0_toggle_pin_o(t0), .timer1_toggle_pin_o(t1),
    .chip_reset_o(crst), .in_system_programming_mode_o(in_system_programming_mode),
    .clock_low_power_select_o(clock_low_power_select)
  );
  acdp_core_model acdp_core_model_inst (.mclk_i(mclk_i), .ptr_op_o(op), .ptr_load_o(ld));

  always #(ACDP_CLK_NS / 2) mclk_i = ~mclk_i;
  always @(negedge mclk_i) if (crst === 1'b1) rst_cyc <= rst_cyc + 1;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    adr  <= a;
    wd   <= d;
    wr_r <= w;
    rd_r <= ~w;
    do @(posedge mclk_i); while (wait_r !== 1'b0);
    q    = rdat;
    wr_r <= 1'b0;
    rd_r <= 1'b0;
    adr  <= ~a;
    wd   <= ~d;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d});
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task settle;
    repeat (6) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask
  task pulse(input logic [2:0] m);
    @(posedge mclk_i);
    pins <= m;
    repeat (3) @(posedge mclk_i);
    pins <= 3'h0;
    settle;
  endtask
  task tend(input string s);
    $display("test %0s done", s);
  endtask
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge mclk_i);
    err_total++;
    final_report;
  end

  initial begin
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rd(ACDP_OFS_AUX, 32'h0);
    chkb(clock_low_power_select, 1'b0);
    chk({16'h0, ptr}, 32'h0);
    tend("reset");
    wr(ACDP_OFS_AUX, 8'hf7);
    rd(ACDP_OFS_AUX, 32'hf3);
    chkb(clock_low_power_select, 1'b1);
    wr(ACDP_OFS_AUX, 8'h03);
    wr(ACDP_OFS_AUX, 8'h04);
    rd(ACDP_OFS_AUX, 32'h00);
    tend("bits");
    acdp_core_model_inst.op(ACDP_OP_LOAD, 16'h1234);
    wr(ACDP_OFS_AUX, 8'h01);
    acdp_core_model_inst.op(ACDP_OP_LOAD, 16'hffff);
    acdp_core_model_inst.op(ACDP_OP_INC, 16'h0000);
    settle;
    chk({16'h0, ptr}, 32'h0000);
    wr(ACDP_OFS_AUX, 8'h00);
    settle;
    chk({16'h0, ptr}, 32'h1234);
    rd(ACDP_OFS_PTR_LO, 32'h34);
    rd(ACDP_OFS_PTR_HI, 32'h12);
    wr(ACDP_OFS_PTR_HI, 8'h56);
    be <= 4'he;
    wr(ACDP_OFS_PTR_LO, 8'h77);
    be <= 4'hf;
    settle;
    chk({16'h0, ptr}, 32'h5634);
    wr(ACDP_OFS_PTR_LO, 8'h9a);
    settle;
    chk({16'h0, ptr}, 32'h569a);
    rd(8'h10, ACDP_UNMAPPED);
    wr(ACDP_OFS_AUX, 8'h01);
    settle;
    chk({16'h0, ptr}, 32'h0000);
    tend("pointers");
    wr(ACDP_OFS_AUX, 8'h10);
    pulse(3'h1);
    chkb(t0, 1'b1);
    pulse(3'h2);
    chkb(t1, 1'b0);
    pulse(3'h1);
    chkb(t0, 1'b0);
    wr(ACDP_OFS_AUX, 8'h30);
    pulse(3'h2);
    chkb(t1, 1'b1);
    tend("toggles");
    wr(ACDP_OFS_AUX, 8'h00);
    b = rst_cyc;
    pulse(3'h4);
    chk(rst_cyc - b, 0);
    chkb(in_system_programming_mode, 1'b0);
    wr(ACDP_OFS_AUX, 8'h41);
    pulse(3'h4);
    chk(rst_cyc - b, ACDP_RST_CYC);
    chkb(in_system_programming_mode, 1'b1);
    rd(ACDP_OFS_STATUS, 32'h2);
    rd(ACDP_OFS_AUX, 32'h0);
    tend("break");
    wr(ACDP_OFS_AUX, 8'h10);
    pulse(3'h1);
    chkb(t0, 1'b1);
    acdp_core_model_inst.op(ACDP_OP_LOAD, 16'hbeef);
    b = rst_cyc;
    wr(ACDP_OFS_AUX, 8'h19);
    settle;
    chk(rst_cyc - b, ACDP_RST_CYC);
    chk({16'h0, ptr}, 32'h0000);
    chkb(t0, 1'b0);
    rd(ACDP_OFS_AUX, 32'h0);
    tend("software reset");
    final_report;
  end
endmodule // tb
